/* hw/hbu_pkg.sv */
// Purpose: shared constants, types and helpers of the host serial port pair.
// Assumes: 100 MHz clock, 8 data bits per character.
// Notes: both ends and the bench import this package; the link carrier does not.
// Function
// RULE1 - receive and transmit run at the same time
// RULE2 - ten separate interrupt causes are reported
// RULE3 - handshake lines are asserted when low
// RULE4 - baud 1200 to 4M, default 115200
// RULE5 - 8 bits, none/odd/even parity, 1/2 stops, flow
// RULE6 - long low receive line resets the device
// RULE7 - device can hold transmit low as break
// RULE8 - device outputs float while held in reset
// RULE9 - sharing parties release the device's lines
// RULE10 - host stops sending while device ready deasserted
// RULE11 - low start, lsb first, parity, high stops
package hbu_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned BAUD_DEF = 115200;
   localparam int unsigned BAUD_MIN = 1200;
   localparam int unsigned BAUD_MAX = 4_000_000;
   localparam int DIV_W = 17;
   typedef logic [DIV_W-1:0] hbu_div_t;
   localparam hbu_div_t DIV_DEF = hbu_div_t'(CLK_HZ / BAUD_DEF);
   localparam hbu_div_t DIV_MAX = hbu_div_t'(CLK_HZ / BAUD_MIN);
   localparam hbu_div_t DIV_MIN = hbu_div_t'((CLK_HZ + BAUD_MAX - 1) / BAUD_MAX);
   localparam int BRK_W = 24;
   localparam int unsigned BRK_TO_US = 10;
   localparam int unsigned BRK_TO_DEF = (CLK_HZ / 1_000_000) * BRK_TO_US;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_DIV = 8'h04;
   localparam logic [7:0] OFF_BRKTO = 8'h08;
   localparam logic [7:0] OFF_DATA = 8'h0c;
   localparam logic [7:0] OFF_STAT = 8'h10;
   localparam logic [7:0] OFF_MASK = 8'h14;
   localparam logic [7:0] OFF_LINE = 8'h18;
   localparam int CTRL_W = 5;
   localparam int CTRL_PAR = 0;
   localparam int CTRL_STOP2 = 2;
   localparam int CTRL_FLOW = 3;
   localparam int CTRL_BRK = 4;
   localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
   localparam int N_EV = 10;
   localparam int EV_RXDONE = 0;
   localparam int EV_TXDONE = 1;
   localparam int EV_PERR = 2;
   localparam int EV_FERR = 3;
   localparam int EV_OVR = 4;
   localparam int EV_BRKDET = 5;
   localparam int EV_CTSON = 6;
   localparam int EV_CTSOFF = 7;
   localparam int EV_BRKSENT = 8;
   localparam int EV_TXEMPTY = 9;
   localparam int LINE_TXBUSY = 0;
   localparam int LINE_RXFULL = 1;
   localparam int LINE_CTS = 2;
   localparam int LINE_RTS = 3;
   typedef enum logic [1:0] {PAR_NONE = 2'b00, PAR_ODD = 2'b01, PAR_EVEN = 2'b10} hbu_par_e;
   typedef enum logic [2:0] {RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
                             RX_PAR = 3'b011, RX_STOP = 3'b100} hbu_rx_e;
   typedef enum logic [2:0] {TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
                             TX_PAR = 3'b011, TX_STOP = 3'b100, TX_BRK = 3'b101} hbu_tx_e;

   // parity bit that makes the character's count of ones odd or even
   function automatic logic par_bit(input logic [7:0] d, input logic [1:0] mode);
      par_bit = (^d) ^ (mode == PAR_ODD);
   endfunction

   function automatic logic par_on(input logic [1:0] mode);
      par_on = (mode == PAR_ODD) || (mode == PAR_EVEN);
   endfunction
endpackage

/* hw/hbu_link_if.sv */
// Purpose: serial wires between the device end and the host end.
// Assumes: pull-ups hold undriven device lines high.
// Notes: the resolved levels are what the host end receives.
interface hbu_link_if;
   logic dev_tx;
   logic dev_tx_oe;
   logic dev_rts_n;
   logic dev_rts_n_oe;
   logic host_tx;
   logic host_rts_n;
   logic tx_line;
   logic rts_line;
   assign tx_line = dev_tx_oe ? dev_tx : 1'b1;
   assign rts_line = dev_rts_n_oe ? dev_rts_n : 1'b1;
   modport dev (input host_tx, input host_rts_n,
                output dev_tx, output dev_tx_oe, output dev_rts_n, output dev_rts_n_oe);
   modport host (input tx_line, input rts_line, output host_tx, output host_rts_n);
endinterface

/* hw/hbu_dev.sv */
// Purpose: device end of the host serial port with registers and break reset.
// Assumes: host end drives its lines from its own clocked logic.
// Notes: a break longer than the timeout pulses o_brk_rst and resets this block.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
module hbu_dev
   import hbu_pkg::*;
#(
   parameter int unsigned BRK_TO_CYC = BRK_TO_DEF
)
(
   input wire logic i_mclk,
   input wire logic i_srst,
   hbu_link_if.dev link,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_irq,
   output logic o_brk_rst
);
   logic rx_m, rx_s, cts_m, cts_s, cts_d;
   logic rst, self_rst, next_self_rst, brk_hit, next_brk_hit;
   logic [BRK_W-1:0] brk_cnt, next_brk_cnt;
   logic [CTRL_W-1:0] ctrl, next_ctrl;
   hbu_div_t div, next_div;
   logic [BRK_W-1:0] brk_to, next_brk_to;
   logic [N_EV-1:0] stat, next_stat, mask, next_mask, ev;
   logic [31:0] rdata, next_rdata;
   logic irq, next_irq, oe, rts_n, next_rts_n;
   logic tx_have, next_tx_have, rx_full, next_rx_full;
   logic [7:0] tx_hold, next_tx_hold, rx_buf, next_rx_buf;
   hbu_rx_e rx_st, next_rx_st;
   hbu_div_t rx_cnt, next_rx_cnt;
   logic [2:0] rx_bit, next_rx_bit;
   logic [7:0] rx_sh, next_rx_sh;
   logic rx_pe, next_rx_pe, rx_ok, rx_fe, rx_tick, rx_load;
   hbu_tx_e tx_st, next_tx_st;
   hbu_div_t tx_cnt, next_tx_cnt;
   logic [2:0] tx_bit, next_tx_bit;
   logic [7:0] tx_sh, next_tx_sh;
   logic tx_stopn, next_tx_stopn, tx_line, next_tx_line;
   logic tx_take, tx_done, brk_done, tx_tick;
   logic wr_data, rd_data, rd_stat;

   function automatic hbu_div_t clamp_div(input hbu_div_t d);
      clamp_div = (d < DIV_MIN) ? DIV_MIN : ((d > DIV_MAX) ? DIV_MAX : d);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and break timer; the timer survives its own reset pulse
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         rx_m <= 1'b1;
         rx_s <= 1'b1;
         cts_m <= 1'b1;
         cts_s <= 1'b1;
         cts_d <= 1'b1;
      end
      else
      begin
         rx_m <= link.host_tx;
         rx_s <= rx_m;
         cts_m <= link.host_rts_n;
         cts_s <= cts_m;
         cts_d <= cts_s;
      end
   end

   always_comb
   begin
      next_brk_cnt = brk_cnt;
      next_brk_hit = brk_hit;
      next_self_rst = 1'b0;
      if (rx_s)
      begin
         next_brk_cnt = '0;
         next_brk_hit = 1'b0;
      end
      else if (!brk_hit)
      begin
         if (brk_cnt >= brk_to)
         begin
            next_self_rst = 1'b1; // RULE6
            next_brk_hit = 1'b1;
         end
         else
            next_brk_cnt = brk_cnt + 1'b1;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         brk_cnt <= '0;
         brk_hit <= 1'b0;
         self_rst <= 1'b0;
      end
      else
      begin
         brk_cnt <= next_brk_cnt;
         brk_hit <= next_brk_hit;
         self_rst <= next_self_rst;
      end
   end

   assign rst = i_srst | self_rst;

   ////////////////////////////////////////////////////////////////////////////////
   // receiver: samples mid-bit, runs independently of the transmitter
   always_comb
   begin
      next_rx_st = rx_st;
      next_rx_cnt = rx_cnt;
      next_rx_bit = rx_bit;
      next_rx_sh = rx_sh;
      next_rx_pe = rx_pe;
      rx_ok = 1'b0;
      rx_fe = 1'b0;
      rx_tick = (rx_cnt == '0);
      if (rx_st != RX_IDLE)
         next_rx_cnt = rx_tick ? div - 1'b1 : rx_cnt - 1'b1;
      unique case (rx_st)
         RX_IDLE:
            if (!rx_s)
            begin
               next_rx_st = RX_START; // RULE11
               next_rx_cnt = div >> 1;
               next_rx_pe = 1'b0;
            end
         RX_START:
            if (rx_tick)
            begin
               next_rx_st = rx_s ? RX_IDLE : RX_DATA;
               next_rx_bit = '0;
            end
         RX_DATA:
            if (rx_tick)
            begin
               next_rx_sh = {rx_s, rx_sh[7:1]}; // RULE11
               next_rx_bit = rx_bit + 1'b1;
               if (rx_bit == 3'h7)
                  next_rx_st = par_on(ctrl[CTRL_PAR +: 2]) ? RX_PAR : RX_STOP; // RULE5
            end
         RX_PAR:
            if (rx_tick)
            begin
               next_rx_pe = rx_s != par_bit(rx_sh, ctrl[CTRL_PAR +: 2]); // RULE5
               next_rx_st = RX_STOP;
            end
         RX_STOP:
            if (rx_tick)
            begin
               next_rx_st = RX_IDLE;
               rx_ok = 1'b1; // RULE1
               rx_fe = !rx_s;
            end
      endcase
   end

   always_ff @(posedge i_mclk)
   begin
      if (rst)
      begin
         rx_st <= RX_IDLE;
         rx_cnt <= '0;
         rx_bit <= '0;
         rx_sh <= '0;
         rx_pe <= 1'b0;
      end
      else
      begin
         rx_st <= next_rx_st;
         rx_cnt <= next_rx_cnt;
         rx_bit <= next_rx_bit;
         rx_sh <= next_rx_sh;
         rx_pe <= next_rx_pe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // transmitter: waits for clear-to-send low when flow control is on
   always_comb
   begin
      next_tx_st = tx_st;
      next_tx_cnt = tx_cnt;
      next_tx_bit = tx_bit;
      next_tx_sh = tx_sh;
      next_tx_stopn = tx_stopn;
      next_tx_line = tx_line;
      tx_take = 1'b0;
      tx_done = 1'b0;
      brk_done = 1'b0;
      tx_tick = (tx_cnt == '0);
      if (tx_st != TX_IDLE && tx_st != TX_BRK)
         next_tx_cnt = tx_tick ? div - 1'b1 : tx_cnt - 1'b1;
      unique case (tx_st)
         TX_IDLE:
            if (ctrl[CTRL_BRK])
            begin
               next_tx_st = TX_BRK;
               next_tx_line = 1'b0; // RULE7
            end
            else if (tx_have && (!ctrl[CTRL_FLOW] || !cts_s)) // RULE3
            begin
               tx_take = 1'b1;
               next_tx_st = TX_START;
               next_tx_line = 1'b0; // RULE11
               next_tx_cnt = div - 1'b1;
               next_tx_sh = tx_hold;
            end
         TX_START:
            if (tx_tick)
            begin
               next_tx_st = TX_DATA;
               next_tx_line = tx_sh[0];
               next_tx_bit = '0;
            end
         TX_DATA:
            if (tx_tick)
            begin
               next_tx_bit = tx_bit + 1'b1;
               next_tx_stopn = 1'b0;
               if (tx_bit == 3'h7)
               begin
                  next_tx_st = par_on(ctrl[CTRL_PAR +: 2]) ? TX_PAR : TX_STOP; // RULE5
                  next_tx_line = par_on(ctrl[CTRL_PAR +: 2]) ?
                                 par_bit(tx_sh, ctrl[CTRL_PAR +: 2]) : 1'b1;
               end
               else
                  next_tx_line = tx_sh[tx_bit + 3'h1]; // RULE11
            end
         TX_PAR:
            if (tx_tick)
            begin
               next_tx_st = TX_STOP;
               next_tx_line = 1'b1;
            end
         TX_STOP:
            if (tx_tick)
            begin
               if (ctrl[CTRL_STOP2] && !tx_stopn) // RULE5
                  next_tx_stopn = 1'b1;
               else
               begin
                  next_tx_st = TX_IDLE;
                  tx_done = 1'b1;
               end
            end
         TX_BRK:
            if (!ctrl[CTRL_BRK])
            begin
               next_tx_st = TX_IDLE;
               next_tx_line = 1'b1;
               brk_done = 1'b1;
            end
         default:
            next_tx_st = TX_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk)
   begin
      if (rst)
      begin
         tx_st <= TX_IDLE;
         tx_cnt <= '0;
         tx_bit <= '0;
         tx_sh <= '0;
         tx_stopn <= 1'b0;
         tx_line <= 1'b1;
      end
      else
      begin
         tx_st <= next_tx_st;
         tx_cnt <= next_tx_cnt;
         tx_bit <= next_tx_bit;
         tx_sh <= next_tx_sh;
         tx_stopn <= next_tx_stopn;
         tx_line <= next_tx_line;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register port, buffers, interrupt and line drivers
   assign wr_data = i_wr && (i_addr == OFF_DATA);
   assign rd_data = i_rd && (i_addr == OFF_DATA);
   assign rd_stat = i_rd && (i_addr == OFF_STAT);
   assign rx_load = rx_ok && (!rx_full || rd_data);

   always_comb
   begin
      ev = '0;
      ev[EV_RXDONE] = rx_ok; // RULE2
      ev[EV_TXDONE] = tx_done;
      ev[EV_PERR] = rx_ok && rx_pe;
      ev[EV_FERR] = rx_fe;
      ev[EV_OVR] = rx_ok && !rx_load;
      ev[EV_BRKDET] = rx_fe && (rx_sh == 8'h00);
      ev[EV_CTSON] = cts_d && !cts_s;
      ev[EV_CTSOFF] = !cts_d && cts_s;
      ev[EV_BRKSENT] = brk_done;
      ev[EV_TXEMPTY] = tx_take;
      next_ctrl = (i_wr && i_addr == OFF_CTRL) ? i_wdata[CTRL_W-1:0] : ctrl;
      next_div = (i_wr && i_addr == OFF_DIV) ? clamp_div(i_wdata[DIV_W-1:0]) : div; // RULE4
      next_brk_to = (i_wr && i_addr == OFF_BRKTO) ? i_wdata[BRK_W-1:0] : brk_to; // RULE6
      next_mask = (i_wr && i_addr == OFF_MASK) ? i_wdata[N_EV-1:0] : mask;
      // an event in the clearing read's cycle stays set
      next_stat = (rd_stat ? '0 : stat) | ev;
      next_irq = |(next_stat & next_mask);
      next_tx_have = (tx_have && !tx_take) || (wr_data && !tx_have);
      next_tx_hold = (wr_data && !tx_have) ? i_wdata[7:0] : tx_hold;
      next_rx_full = (rx_full && !rd_data) || rx_load;
      next_rx_buf = rx_load ? rx_sh : rx_buf;
      next_rts_n = ctrl[CTRL_FLOW] && next_rx_full; // RULE3
      next_rdata = '0;
      if (i_rd)
      begin
         unique case (i_addr)
            OFF_CTRL: next_rdata[CTRL_W-1:0] = ctrl;
            OFF_DIV: next_rdata[DIV_W-1:0] = div;
            OFF_BRKTO: next_rdata[BRK_W-1:0] = brk_to;
            OFF_DATA: next_rdata[7:0] = rx_buf;
            OFF_STAT: next_rdata[N_EV-1:0] = stat;
            OFF_MASK: next_rdata[N_EV-1:0] = mask;
            OFF_LINE: next_rdata[3:0] = {!rts_n, !cts_s, rx_full, tx_have || tx_st != TX_IDLE};
            default: next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (rst)
      begin
         ctrl <= CTRL_RST;
         div <= DIV_DEF;
         brk_to <= BRK_W'(BRK_TO_CYC);
         mask <= '0;
         stat <= '0;
         irq <= 1'b0;
         rdata <= '0;
         tx_have <= 1'b0;
         tx_hold <= '0;
         rx_full <= 1'b0;
         rx_buf <= '0;
         rts_n <= 1'b1;
         oe <= 1'b0; // RULE8
      end
      else
      begin
         ctrl <= next_ctrl;
         div <= next_div;
         brk_to <= next_brk_to;
         mask <= next_mask;
         stat <= next_stat;
         irq <= next_irq;
         rdata <= next_rdata;
         tx_have <= next_tx_have;
         tx_hold <= next_tx_hold;
         rx_full <= next_rx_full;
         rx_buf <= next_rx_buf;
         rts_n <= next_rts_n;
         oe <= 1'b1;
      end
   end

   assign o_rdata = rdata;
   assign o_irq = irq;
   assign o_brk_rst = self_rst;
   assign link.dev_tx = tx_line;
   assign link.dev_rts_n = rts_n;
   assign link.dev_tx_oe = oe; // RULE8
   assign link.dev_rts_n_oe = oe;
endmodule

/* hw/hbu_host.sv */
// Purpose: host end of the serial port, a plain character streamer.
// Assumes: settings inputs stay steady while characters are in flight.
// Notes: drives only its own two lines; device lines are inputs only.
module hbu_host
   import hbu_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_srst,
   hbu_link_if.host link,
   input wire hbu_div_t i_div,
   input wire logic [1:0] i_par,
   input wire logic i_stop2,
   input wire logic i_flow,
   input wire logic [7:0] i_tx_data,
   input wire logic i_tx_valid,
   output logic o_tx_ready,
   input wire logic i_brk,
   input wire logic i_rx_hold,
   output logic [7:0] o_rx_data,
   output logic o_rx_valid,
   output logic o_rx_perr,
   output logic o_rx_ferr
);
   logic rx_m, rx_s, rts_m, rts_s;
   hbu_rx_e rx_st, next_rx_st;
   hbu_tx_e tx_st, next_tx_st;
   hbu_div_t rx_cnt, next_rx_cnt, tx_cnt, next_tx_cnt;
   logic [2:0] rx_bit, next_rx_bit, tx_bit, next_tx_bit;
   logic [7:0] rx_sh, next_rx_sh, tx_sh, next_tx_sh, rx_data;
   logic rx_pe, next_rx_pe, rx_valid, rx_perr, rx_ferr, rx_ok;
   logic tx_stopn, next_tx_stopn, tx_line, next_tx_line;
   logic tx_ready, next_tx_ready, rts_n;

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         rx_m <= 1'b1;
         rx_s <= 1'b1;
         rts_m <= 1'b1;
         rts_s <= 1'b1;
      end
      else
      begin
         rx_m <= link.tx_line;
         rx_s <= rx_m;
         rts_m <= link.rts_line;
         rts_s <= rts_m;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_rx_st = rx_st;
      next_rx_cnt = rx_cnt;
      next_rx_bit = rx_bit;
      next_rx_sh = rx_sh;
      next_rx_pe = rx_pe;
      rx_ok = 1'b0;
      if (rx_st != RX_IDLE)
         next_rx_cnt = (rx_cnt == '0) ? i_div - 1'b1 : rx_cnt - 1'b1; // RULE4
      unique case (rx_st)
         RX_IDLE:
            if (!rx_s)
            begin
               next_rx_st = RX_START; // RULE11
               next_rx_cnt = i_div >> 1;
               next_rx_pe = 1'b0;
            end
         RX_START:
            if (rx_cnt == '0)
            begin
               next_rx_st = rx_s ? RX_IDLE : RX_DATA;
               next_rx_bit = '0;
            end
         RX_DATA:
            if (rx_cnt == '0)
            begin
               next_rx_sh = {rx_s, rx_sh[7:1]}; // RULE11
               next_rx_bit = rx_bit + 1'b1;
               if (rx_bit == 3'h7)
                  next_rx_st = par_on(i_par) ? RX_PAR : RX_STOP; // RULE5
            end
         RX_PAR:
            if (rx_cnt == '0)
            begin
               next_rx_pe = rx_s != par_bit(rx_sh, i_par);
               next_rx_st = RX_STOP;
            end
         RX_STOP:
            if (rx_cnt == '0)
            begin
               next_rx_st = RX_IDLE;
               rx_ok = 1'b1;
            end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_tx_st = tx_st;
      next_tx_cnt = tx_cnt;
      next_tx_bit = tx_bit;
      next_tx_sh = tx_sh;
      next_tx_stopn = tx_stopn;
      next_tx_line = tx_line;
      if (tx_st != TX_IDLE && tx_st != TX_BRK)
         next_tx_cnt = (tx_cnt == '0) ? i_div - 1'b1 : tx_cnt - 1'b1;
      unique case (tx_st)
         TX_IDLE:
            if (i_brk)
            begin
               next_tx_st = TX_BRK;
               next_tx_line = 1'b0;
            end
            else if (i_tx_valid && tx_ready)
            begin
               next_tx_st = TX_START;
               next_tx_line = 1'b0;
               next_tx_cnt = i_div - 1'b1;
               next_tx_sh = i_tx_data;
            end
         TX_START:
            if (tx_cnt == '0)
            begin
               next_tx_st = TX_DATA;
               next_tx_line = tx_sh[0];
               next_tx_bit = '0;
            end
         TX_DATA:
            if (tx_cnt == '0)
            begin
               next_tx_bit = tx_bit + 1'b1;
               next_tx_stopn = 1'b0;
               if (tx_bit == 3'h7)
               begin
                  next_tx_st = par_on(i_par) ? TX_PAR : TX_STOP;
                  next_tx_line = par_on(i_par) ? par_bit(tx_sh, i_par) : 1'b1;
               end
               else
                  next_tx_line = tx_sh[tx_bit + 3'h1]; // RULE11
            end
         TX_PAR:
            if (tx_cnt == '0)
            begin
               next_tx_st = TX_STOP;
               next_tx_line = 1'b1;
            end
         TX_STOP:
            if (tx_cnt == '0)
            begin
               if (i_stop2 && !tx_stopn)
                  next_tx_stopn = 1'b1;
               else
                  next_tx_st = TX_IDLE;
            end
         TX_BRK:
            if (!i_brk)
            begin
               next_tx_st = TX_IDLE;
               next_tx_line = 1'b1;
            end
         default:
            next_tx_st = TX_IDLE;
      endcase
      // no new character while the device holds its ready line high
      next_tx_ready = (next_tx_st == TX_IDLE) && !i_brk && (!i_flow || !rts_s); // RULE10
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         rx_st <= RX_IDLE;
         rx_cnt <= '0;
         rx_bit <= '0;
         rx_sh <= '0;
         rx_pe <= 1'b0;
         rx_data <= '0;
         rx_valid <= 1'b0;
         rx_perr <= 1'b0;
         rx_ferr <= 1'b0;
         tx_st <= TX_IDLE;
         tx_cnt <= '0;
         tx_bit <= '0;
         tx_sh <= '0;
         tx_stopn <= 1'b0;
         tx_line <= 1'b1;
         tx_ready <= 1'b0;
         rts_n <= 1'b1;
      end
      else
      begin
         rx_st <= next_rx_st;
         rx_cnt <= next_rx_cnt;
         rx_bit <= next_rx_bit;
         rx_sh <= next_rx_sh;
         rx_pe <= next_rx_pe;
         rx_data <= rx_ok ? rx_sh : rx_data;
         rx_valid <= rx_ok;
         rx_perr <= rx_ok && rx_pe;
         rx_ferr <= rx_ok && !rx_s;
         tx_st <= next_tx_st;
         tx_cnt <= next_tx_cnt;
         tx_bit <= next_tx_bit;
         tx_sh <= next_tx_sh;
         tx_stopn <= next_tx_stopn;
         tx_line <= next_tx_line;
         tx_ready <= next_tx_ready;
         rts_n <= i_flow && i_rx_hold; // RULE3
      end
   end

   assign o_tx_ready = tx_ready;
   assign o_rx_data = rx_data;
   assign o_rx_valid = rx_valid;
   assign o_rx_perr = rx_perr;
   assign o_rx_ferr = rx_ferr;
   // only the host's own lines are driven; device lines stay released
   assign link.host_tx = tx_line; // RULE9
   assign link.host_rts_n = rts_n;
endmodule

/* verif/hbu_link_props.sv */
// Purpose: checks on the serial wires between both ends
// Assumes: one clock, sync reset; every bit lasts at least 25 cycles
// Notes: 8-cycle holds stay far below any legal bit time
module hbu_link_props
(
   input wire logic i_mclk,
   input wire logic i_srst,
   input wire logic dev_tx,
   input wire logic dev_tx_oe,
   input wire logic dev_rts_n,
   input wire logic dev_rts_n_oe,
   input wire logic host_tx,
   input wire logic host_rts_n,
   input wire logic tx_line,
   input wire logic rts_line
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   // a self reset drops the enables, so edges next to one are not counted
   sequence s_dev_fall;
      $fell(tx_line) && dev_tx_oe && $past(dev_tx_oe);
   endsequence
   sequence s_dev_rise;
      $rose(tx_line) && dev_tx_oe && $past(dev_tx_oe);
   endsequence
   a_oe_float: assert property ($fell(i_srst) |-> !dev_tx_oe && tx_line && rts_line)
      else $error("device lines driven in reset");
   a_oe_after: assert property ($fell(i_srst) |=> dev_tx_oe)
      else $error("device lines not driven after reset");
   a_oe_pair: assert property (dev_tx_oe == dev_rts_n_oe)
      else $error("enables differ");
   a_host_idle: assert property ($fell(i_srst) |-> host_tx && host_rts_n)
      else $error("host lines not idle");
   a_dev_start: assert property (s_dev_fall |=> !tx_line [*8])
      else $error("device low bit too short");
   a_dev_stop: assert property (s_dev_rise |=> tx_line [*8])
      else $error("device high bit too short");
   a_host_start: assert property ($fell(host_tx) |=> !host_tx [*8])
      else $error("host low bit too short");
   a_host_stop: assert property ($rose(host_tx) |=> host_tx [*8])
      else $error("host high bit too short");
endmodule

/* verif/hbu_tb_top.sv */
// Purpose: bench of the device and host ends joined by their link
// Assumes: host framing follows the device control register
// Notes: break timeout cut to 200 cycles to keep the run short
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("[ERR] %0t %h %h", $time, a, e); end end
module hbu_tb_top
   import hbu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk = 1'b0, i_srst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic h_val = 1'b0, h_brk = 1'b0, h_stop2 = 1'b0, h_rdy, h_rxv, h_perr, h_ferr, irq, brk;
   logic h_flow = 1'b0, h_hold = 1'b0;
   logic [7:0] addr = 8'h00, h_dat = 8'h00, h_rxd;
   logic [31:0] wdat = 32'h0, rdat;
   logic [1:0] h_par = 2'h0;
   int error_cnt = 0, checks = 0, cyc = 0;
   hbu_link_if lnk();
   hbu_dev #(.BRK_TO_CYC(200)) hbu_dev_i (.i_mclk, .i_srst, .link(lnk), .i_addr(addr),
      .i_wdata(wdat), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .o_irq(irq), .o_brk_rst(brk));
   hbu_host hbu_host_i (.i_mclk, .i_srst, .link(lnk), .i_div(DIV_MIN), .i_par(h_par),
      .i_stop2(h_stop2), .i_flow(h_flow), .i_tx_data(h_dat), .i_tx_valid(h_val),
      .o_tx_ready(h_rdy), .i_brk(h_brk), .i_rx_hold(h_hold), .o_rx_data(h_rxd),
      .o_rx_valid(h_rxv), .o_rx_perr(h_perr), .o_rx_ferr(h_ferr));
   hbu_link_props hbu_link_props_i (.i_mclk, .i_srst, .dev_tx(lnk.dev_tx),
      .dev_tx_oe(lnk.dev_tx_oe), .dev_rts_n(lnk.dev_rts_n), .dev_rts_n_oe(lnk.dev_rts_n_oe),
      .host_tx(lnk.host_tx), .host_rts_n(lnk.host_rts_n), .tx_line(lnk.tx_line),
      .rts_line(lnk.rts_line));
   always #5 i_mclk = ~i_mclk;
   task automatic complete_run();
      if (error_cnt == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // the whole run needs about 2000 cycles
   always @(posedge i_mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(posedge i_mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
      @(posedge i_mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_mclk);
      rd <= 1'b0;
      @(posedge i_mclk);
      `CHK(rdat & m, e)
   endtask
   initial
   begin
      logic [7:0] b;
      int t;
      repeat (10) @(posedge i_mclk);
      i_srst <= 1'b0;
      rd_reg(OFF_CTRL, 32'h0);
      rd_reg(OFF_DIV, 32'h364);
      rd_reg(OFF_BRKTO, 32'hc8);
      rd_reg(OFF_MASK, 32'h0);
      rd_reg(8'h1c, 32'h0);
      wr_reg(OFF_DIV, 32'(DIV_MIN));
      wr_reg(OFF_MASK, 32'h1);
      // both directions run at once with each parity mode; two stop bits only with odd parity
      for (int m = 0; m < 3; m++)
      begin
         b = 8'ha5 ^ {m[3:0], m[3:0]};
         h_par <= m[1:0];
         h_stop2 <= m[0];
         wr_reg(OFF_CTRL, {29'h0, m[0], m[1:0]});
         wr_reg(OFF_DATA, {24'h0, b});
         h_dat <= ~b;
         h_val <= 1'b1;
         do @(posedge i_mclk); while (h_rdy !== 1'b1);
         h_val <= 1'b0;
         while (h_rxv !== 1'b1) @(posedge i_mclk);
         `CHK({h_rxd, h_perr, h_ferr}, {b, 2'b00})
         while (irq !== 1'b1) @(posedge i_mclk);
         rd_reg(OFF_STAT, 32'h1, 32'h1);
         `CHK(irq, 1'b0)
         rd_reg(OFF_DATA, {24'h0, ~b});
         repeat (60) @(posedge i_mclk);
      end
      // flow on: the device holds its character while the host is not ready; the host then shows not ready while the device buffer is full
      h_par <= 2'h0;
      h_flow <= 1'b1;
      h_hold <= 1'b1;
      wr_reg(OFF_CTRL, 32'h8);
      wr_reg(OFF_DATA, 32'h3c);
      repeat (40) @(posedge i_mclk);
      `CHK(lnk.tx_line, 1'b1)
      h_hold <= 1'b0;
      while (h_rxv !== 1'b1) @(posedge i_mclk);
      `CHK({h_rxd, h_perr, h_ferr}, {8'h3c, 2'b00})
      h_dat <= 8'hc3;
      h_val <= 1'b1;
      do @(posedge i_mclk); while (h_rdy !== 1'b1);
      h_val <= 1'b0;
      while (irq !== 1'b1) @(posedge i_mclk);
      repeat (40) @(posedge i_mclk);
      `CHK(h_rdy, 1'b0)
      rd_reg(OFF_LINE, 32'h6);
      rd_reg(OFF_DATA, 32'hc3);
      wr_reg(OFF_CTRL, 32'h10);
      repeat (10) @(posedge i_mclk);
      `CHK(lnk.tx_line, 1'b0)
      wr_reg(OFF_CTRL, 32'h0);
      repeat (10) @(posedge i_mclk);
      `CHK(lnk.tx_line, 1'b1)
      t = cyc;
      h_brk <= 1'b1;
      while (brk !== 1'b1) @(posedge i_mclk);
      `CHK((cyc - t) inside {[200:215]}, 1'b1)
      rd_reg(OFF_DIV, 32'h364);
      h_brk <= 1'b0;
      repeat (50) @(posedge i_mclk);
      complete_run();
   end
endmodule
